/* File: shared/hsc_pkg.sv */
// Summary of operation
// - One-shot: run drops at zero, sync restarts
// - Threshold outputs follow count and direction
// - One-shot: wrap flag rises at zero
// - Sync flag rises on every sync event
// - Capture flag set; no recapture until cleared
// - Report reflex states and physical outputs
// - Validity true only while outputs valid
// - Error output with separate diagnostic code
// - Preset and thresholds writable, override configuration
// - Restart restores configured parameters
// - One-shot ordering: 0<th0<th1<preset-1
// - Preset below threshold one is rejected
// - Modulo sync activates and clears count
// - Count up on A or A-led pair; simple modulo counts A down
// - Quadrature: count down on B-led pair
// - Up from modulo-1 wraps to zero
// - Down from zero wraps to modulo-1
// - Disabled: pulses ignored, count held except on a sync edge or restart
// - Acknowledge rising edges clear sync, capture
// - Compare hold freezes fast outputs and threshold levels
package hsc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_PRESET = 8'h0c;
  localparam logic [7:0] OFS_TH0 = 8'h10;
  localparam logic [7:0] OFS_TH1 = 8'h14;
  localparam logic [7:0] OFS_CAPTURE = 8'h18;
  localparam logic [7:0] OFS_DIAG = 8'h1c;
  // Control register fields; bit 7 is a self-clearing restart strobe.
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_MODULO = 0;
  localparam int unsigned CTRL_QUAD = 1;
  localparam int unsigned CTRL_SIMPLE = 2;
  localparam int unsigned CTRL_REFLEX_ZERO_STATE = 3;
  localparam int unsigned CTRL_REFLEX_ONE_STATE = 4;
  localparam int unsigned CTRL_HOLD = 5;
  localparam int unsigned CTRL_ENABLE = 6;
  localparam int unsigned CTRL_RESTART = 7;
  localparam logic [6:0] CTRL_RST = 7'h40;
  // Status register fields.
  localparam int unsigned ST_RUN = 0;
  localparam int unsigned ST_VALID = 1;
  localparam int unsigned ST_ERROR = 2;
  localparam int unsigned ST_TH0 = 3;
  localparam int unsigned ST_TH1 = 4;
  localparam int unsigned ST_WRAP = 5;
  localparam int unsigned ST_SYNC = 6;
  localparam int unsigned ST_CAP = 7;
  localparam int unsigned ST_REFLEX_ZERO_STATE = 8;
  localparam int unsigned ST_REFLEX_ONE_STATE = 9;
  localparam int unsigned ST_PHYSICAL_OUTPUT_ZERO_STATE = 10;
  localparam int unsigned ST_PHYSICAL_OUTPUT_ONE_STATE = 11;
  // Configured parameter values restored at every start.
  localparam logic [31:0] PRESET_RST = 32'h0000012c;
  localparam logic [31:0] TH0_RST = 32'h00000064;
  localparam logic [31:0] TH1_RST = 32'h000000c8;
  typedef enum logic [1:0] {
    DIAG_NONE = 2'b00,
    DIAG_PRESET = 2'b01,
    DIAG_THRESH = 2'b10,
    DIAG_ADDR = 2'b11
  } diag_code_t;
  typedef enum logic {
    RUN_IDLE = 1'b0,
    RUN_ACTIVE = 1'b1
  } run_state_t;
endpackage

/* File: hdl/pulse_decoder.sv */
`timescale 1ns/100ps
// Turns the A and B inputs into one-cycle up and down count pulses.
module pulse_decoder (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic a_in, // Counting input A.
  input wire logic b_in, // Counting input B.
  input wire logic quad, // Quadrature decoding selected.
  input wire logic simple, // Reduced single-input variant.
  input wire logic modulo, // Modulo-loop mode selected.
  input wire logic enable, // Enable condition.
  output logic up_step, // One-cycle count-up pulse.
  output logic down_step // One-cycle count-down pulse.
);
  logic a_q;
  logic b_q;
  logic a_rise;
  logic b_rise;

  // Edge history; inputs are taken as synchronous to pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a_in;
      b_q <= b_in;
    end
  end

  assign a_rise = a_in & ~a_q;
  assign b_rise = b_in & ~b_q;

  // A pair led by A rises on A with B low; led by B the other way round.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_step <= 1'b0;
      down_step <= 1'b0;
    end else if (!enable) begin
      up_step <= 1'b0;
      down_step <= 1'b0;
    end else if (simple) begin
      up_step <= a_rise & ~modulo;
      down_step <= a_rise & modulo;
    end else if (quad) begin
      up_step <= a_rise & ~b_in;
      down_step <= b_rise & ~a_in;
    end else begin
      up_step <= a_rise;
      down_step <= 1'b0;
    end
  end
endmodule // pulse_decoder

/* File: hdl/threshold_track.sv */
`timescale 1ns/100ps
// Tracks one threshold output from the count and counting direction.
module threshold_track #(
  parameter int unsigned CW = 32
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic restart, // Warm restart strobe.
  input wire logic up_step, // Count moved up this cycle.
  input wire logic down_step, // Count moved down this cycle.
  input wire logic hold, // Compare results suspended.
  input wire logic signed [CW-1:0] count_next, // Count after the step.
  input wire logic signed [CW-1:0] threshold, // Threshold value.
  output logic level // Threshold output.
);
  // Apart from restart, only a step can change the level, so a level set
  // while counting up survives a later threshold rewrite.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
    end else if (restart) begin
      level <= 1'b0;
    end else if (!hold) begin
      if (up_step && count_next >= threshold) begin
        level <= 1'b1;
      end else if (down_step && count_next <= threshold) begin
        level <= 1'b0;
      end
    end
  end

  chk_level_up: assert property (@(posedge pclk) disable iff (!presetn)
    !restart && !hold && up_step && count_next >= threshold |=> level)
    else $error("threshold output not set while counting up");
endmodule // threshold_track

/* File: hdl/hsc_counter.sv */
`timescale 1ns/100ps
// High speed counter with one-shot and modulo-loop modes behind APB.
module hsc_counter #(
  parameter int unsigned CW = 32,
  parameter logic [31:0] CFG_PRESET = hsc_pkg::PRESET_RST,
  parameter logic [31:0] CFG_TH0 = hsc_pkg::TH0_RST,
  parameter logic [31:0] CFG_TH1 = hsc_pkg::TH1_RST
) (
  input wire logic pclk, // System clock, 125 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic a_in, // Counting input A.
  input wire logic b_in, // Counting input B.
  input wire logic enable_in, // Enable condition.
  input wire logic sync_in, // Synchronization condition.
  input wire logic capture_in, // Capture condition.
  input wire logic ack_sync, // Rising edge clears sync flag.
  input wire logic ack_cap, // Rising edge clears capture flag.
  input wire logic ack_wrap, // Rising edge clears wrap flag.
  input wire logic warm_restart, // Pulse restores configured parameters.
  output logic fast_output_zero, // Fast physical output 0.
  output logic fast_output_one, // Fast physical output 1.
  output logic run, // Counter running.
  output logic validity, // Reported values valid.
  output logic error // Error detected.
);
  initial begin
    if (CW < 8 || CW > 32) begin
      $error("hsc_counter: CW must lie between 8 and 32");
    end
  end

  logic [6:0] ctrl;
  logic signed [CW-1:0] present_count;
  logic signed [CW-1:0] next_count;
  logic signed [CW-1:0] preset_parameter;
  logic signed [CW-1:0] threshold_zero_parameter;
  logic signed [CW-1:0] threshold_one_parameter;
  logic signed [CW-1:0] capture_value;
  hsc_pkg::run_state_t run_state;
  hsc_pkg::diag_code_t diag;
  logic wrap_flag;
  logic sync_flag;
  logic cap_flag;
  logic threshold_zero_output;
  logic threshold_one_output;
  logic physical_output_zero_state;
  logic physical_output_one_state;
  logic sync_q, cap_q, ack_sync_q, ack_cap_q, ack_wrap_q;
  logic sync_rise, cap_rise, ack_sync_rise, ack_cap_rise, ack_wrap_rise;
  logic up_step, down_step;
  logic modulo_mode, enable;
  logic restart;
  logic wrap_event;
  logic next_run;
  logic acc, wr_done, rd_cycle;
  logic wr_ok;
  logic [31:0] next_rdata;
  hsc_pkg::diag_code_t next_reject;

  assign modulo_mode = ctrl[hsc_pkg::CTRL_MODULO];
  assign enable = enable_in & ctrl[hsc_pkg::CTRL_ENABLE];

  // One-shot ordering check, shared by every parameter write.
  function automatic logic order_ok(input logic modulo, input logic signed [CW-1:0] p,
                                    input logic signed [CW-1:0] t0, input logic signed [CW-1:0] t1);
    if (p < t1) begin
      order_ok = 1'b0;
    end else if (modulo) begin
      order_ok = 1'b1;
    end else begin
      order_ok = (t0 > 0) && (t0 < t1) && (t1 < p - 1);
    end
  endfunction

  // Input history for the edge-triggered conditions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 1'b0;
      cap_q <= 1'b0;
      ack_sync_q <= 1'b0;
      ack_cap_q <= 1'b0;
      ack_wrap_q <= 1'b0;
    end else begin
      sync_q <= sync_in;
      cap_q <= capture_in;
      ack_sync_q <= ack_sync;
      ack_cap_q <= ack_cap;
      ack_wrap_q <= ack_wrap;
    end
  end

  assign sync_rise = sync_in & ~sync_q;
  assign cap_rise = capture_in & ~cap_q;
  assign ack_sync_rise = ack_sync & ~ack_sync_q;
  assign ack_cap_rise = ack_cap & ~ack_cap_q;
  assign ack_wrap_rise = ack_wrap & ~ack_wrap_q;

  // A restart comes from the pin or from the control strobe.
  assign acc = psel & penable & pready;
  assign wr_done = acc & pwrite & ~pslverr;
  assign restart = warm_restart | (wr_done && paddr == hsc_pkg::OFS_CTRL && pwdata[hsc_pkg::CTRL_RESTART]);

  pulse_decoder u_decoder (
    .pclk(pclk),
    .presetn(presetn),
    .a_in(a_in),
    .b_in(b_in),
    .quad(ctrl[hsc_pkg::CTRL_QUAD]),
    .simple(ctrl[hsc_pkg::CTRL_SIMPLE]),
    .modulo(modulo_mode),
    .enable(enable),
    .up_step(up_step),
    .down_step(down_step)
  );

  // Next count and run state; a sync edge beats any pulse in the same cycle.
  always_comb begin
    next_count = present_count;
    next_run = run_state;
    wrap_event = 1'b0;
    if (sync_rise) begin
      next_run = hsc_pkg::RUN_ACTIVE;
      next_count = modulo_mode || ctrl[hsc_pkg::CTRL_SIMPLE] ? '0 : preset_parameter;
    end else if (modulo_mode) begin
      if (up_step) begin
        if (present_count >= preset_parameter - 1) begin
          next_count = '0;
          wrap_event = 1'b1;
        end else begin
          next_count = CW'(present_count + 1);
        end
      end else if (down_step) begin
        if (present_count <= 0) begin
          next_count = CW'(preset_parameter - 1);
          wrap_event = 1'b1;
        end else begin
          next_count = CW'(present_count - 1);
        end
      end
    end else if (run_state == hsc_pkg::RUN_ACTIVE) begin
      if (down_step) begin
        next_count = CW'(present_count - 1);
      end else if (up_step) begin
        next_count = present_count >= preset_parameter - 1 ? '0 : CW'(present_count + 1);
      end
      if ((up_step || down_step) && next_count == 0) begin
        next_run = hsc_pkg::RUN_IDLE;
        wrap_event = 1'b1;
      end
    end
  end

  // Count, run state and capture register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_count <= '0;
      run_state <= hsc_pkg::RUN_IDLE;
      run <= 1'b0;
      capture_value <= '0;
    end else if (restart) begin
      present_count <= '0;
      run_state <= hsc_pkg::RUN_IDLE;
      run <= 1'b0;
    end else begin
      present_count <= next_count;
      run_state <= hsc_pkg::run_state_t'(next_run);
      run <= next_run;
      if (cap_rise && !cap_flag) begin
        capture_value <= present_count;
      end
    end
  end

  // Event flags: a new wrap or sync event in the clearing cycle keeps that flag set; a capture edge does not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag <= 1'b0;
      sync_flag <= 1'b0;
      cap_flag <= 1'b0;
    end else if (restart) begin
      wrap_flag <= 1'b0;
      sync_flag <= 1'b0;
      cap_flag <= 1'b0;
    end else begin
      wrap_flag <= wrap_event | (wrap_flag & ~ack_wrap_rise);
      sync_flag <= sync_rise | (sync_flag & ~ack_sync_rise);
      cap_flag <= (cap_rise & ~cap_flag) | (cap_flag & ~ack_cap_rise);
    end
  end

  threshold_track #(.CW(CW)) u_th0 (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .up_step(up_step & ~sync_rise),
    .down_step(down_step & ~sync_rise),
    .hold(ctrl[hsc_pkg::CTRL_HOLD]),
    .count_next(next_count),
    .threshold(threshold_zero_parameter),
    .level(threshold_zero_output)
  );

  threshold_track #(.CW(CW)) u_th1 (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .up_step(up_step & ~sync_rise),
    .down_step(down_step & ~sync_rise),
    .hold(ctrl[hsc_pkg::CTRL_HOLD]),
    .count_next(next_count),
    .threshold(threshold_one_parameter),
    .level(threshold_one_output)
  );

  // Reflex states are the threshold levels; an unconfigured reflex leaves its output low.
  assign physical_output_zero_state = ctrl[hsc_pkg::CTRL_REFLEX_ZERO_STATE] & threshold_zero_output;
  assign physical_output_one_state = ctrl[hsc_pkg::CTRL_REFLEX_ONE_STATE] & threshold_one_output;

  // Fast outputs freeze while compare results are suspended.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_output_zero <= 1'b0;
      fast_output_one <= 1'b0;
    end else if (!ctrl[hsc_pkg::CTRL_HOLD]) begin
      fast_output_zero <= physical_output_zero_state;
      fast_output_one <= physical_output_one_state;
    end
  end

  // Write check; used in the first access cycle only, its verdict held in pslverr for completion.
  always_comb begin
    next_reject = hsc_pkg::DIAG_NONE;
    if (pwrite) begin
      unique case (paddr)
        hsc_pkg::OFS_CTRL, hsc_pkg::OFS_STATUS, hsc_pkg::OFS_DIAG: next_reject = hsc_pkg::DIAG_NONE;
        hsc_pkg::OFS_PRESET: begin
          if (!order_ok(modulo_mode, CW'(pwdata), threshold_zero_parameter, threshold_one_parameter)) begin
            next_reject = hsc_pkg::DIAG_PRESET;
          end
        end
        hsc_pkg::OFS_TH0: begin
          if (!order_ok(modulo_mode, preset_parameter, CW'(pwdata), threshold_one_parameter)) begin
            next_reject = hsc_pkg::DIAG_THRESH;
          end
        end
        hsc_pkg::OFS_TH1: begin
          if (!order_ok(modulo_mode, preset_parameter, threshold_zero_parameter, CW'(pwdata))) begin
            next_reject = hsc_pkg::DIAG_THRESH;
          end
        end
        default: next_reject = hsc_pkg::DIAG_ADDR;
      endcase
    end
  end
  assign wr_ok = next_reject == hsc_pkg::DIAG_NONE;

  // Runtime parameters override the configured ones until the next start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_parameter <= CW'(CFG_PRESET);
      threshold_zero_parameter <= CW'(CFG_TH0);
      threshold_one_parameter <= CW'(CFG_TH1);
      ctrl <= hsc_pkg::CTRL_RST;
    end else if (restart) begin
      preset_parameter <= CW'(CFG_PRESET);
      threshold_zero_parameter <= CW'(CFG_TH0);
      threshold_one_parameter <= CW'(CFG_TH1);
      if (wr_done && paddr == hsc_pkg::OFS_CTRL) begin
        ctrl <= pwdata[6:0];
      end
    end else if (wr_done) begin
      unique case (paddr)
        hsc_pkg::OFS_CTRL: ctrl <= pwdata[6:0];
        hsc_pkg::OFS_PRESET: preset_parameter <= CW'(pwdata);
        hsc_pkg::OFS_TH0: threshold_zero_parameter <= CW'(pwdata);
        hsc_pkg::OFS_TH1: threshold_one_parameter <= CW'(pwdata);
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Error and diagnostic code; a write to the diagnostic register clears them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error <= 1'b0;
      diag <= hsc_pkg::DIAG_NONE;
    end else if (rd_cycle && pwrite && !wr_ok) begin
      error <= 1'b1;
      diag <= next_reject;
    end else if (restart || (wr_done && paddr == hsc_pkg::OFS_DIAG)) begin
      error <= 1'b0;
      diag <= hsc_pkg::DIAG_NONE;
    end
  end

  // Outputs are invalid for the cycle after reset and after a restart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      validity <= 1'b0;
    end else begin
      validity <= ~restart;
    end
  end

  // Read multiplexer.
  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      hsc_pkg::OFS_CTRL: next_rdata[6:0] = ctrl;
      hsc_pkg::OFS_STATUS: begin
        next_rdata[hsc_pkg::ST_RUN] = run;
        next_rdata[hsc_pkg::ST_VALID] = validity;
        next_rdata[hsc_pkg::ST_ERROR] = error;
        next_rdata[hsc_pkg::ST_TH0] = threshold_zero_output;
        next_rdata[hsc_pkg::ST_TH1] = threshold_one_output;
        next_rdata[hsc_pkg::ST_WRAP] = wrap_flag;
        next_rdata[hsc_pkg::ST_SYNC] = sync_flag;
        next_rdata[hsc_pkg::ST_CAP] = cap_flag;
        next_rdata[hsc_pkg::ST_REFLEX_ZERO_STATE] = threshold_zero_output;
        next_rdata[hsc_pkg::ST_REFLEX_ONE_STATE] = threshold_one_output;
        next_rdata[hsc_pkg::ST_PHYSICAL_OUTPUT_ZERO_STATE] = physical_output_zero_state;
        next_rdata[hsc_pkg::ST_PHYSICAL_OUTPUT_ONE_STATE] = physical_output_one_state;
      end
      hsc_pkg::OFS_COUNT: next_rdata = 32'(present_count);
      hsc_pkg::OFS_PRESET: next_rdata = 32'(preset_parameter);
      hsc_pkg::OFS_TH0: next_rdata = 32'(threshold_zero_parameter);
      hsc_pkg::OFS_TH1: next_rdata = 32'(threshold_one_parameter);
      hsc_pkg::OFS_CAPTURE: next_rdata = 32'(capture_value);
      hsc_pkg::OFS_DIAG: next_rdata[1:0] = diag;
      default: next_rdata = '0;
    endcase
  end

  // APB: every access takes one wait state, so pready comes from a flop.
  assign rd_cycle = psel & penable & ~pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= rd_cycle;
      pslverr <= rd_cycle & (pwrite ? ~wr_ok : (paddr > hsc_pkg::OFS_DIAG || paddr[1:0] != 2'b00));
      prdata <= rd_cycle && !pwrite ? next_rdata : '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_oneshot_stop: assert property (!modulo_mode && run_state == hsc_pkg::RUN_ACTIVE && down_step
    && present_count == 1 && !sync_rise && !restart |=> !run && wrap_flag)
    else $error("one-shot counter did not stop and flag at zero");
  chk_sync_clear: assert property (modulo_mode && sync_rise && !restart
    |=> present_count == 0 && run && sync_flag)
    else $error("sync edge did not clear and start the counter");
  chk_wrap_up: assert property (modulo_mode && up_step && !sync_rise && !restart
    && present_count == preset_parameter - 1 |=> present_count == 0 && wrap_flag)
    else $error("modulo count did not wrap to zero");
  chk_wrap_down: assert property (modulo_mode && down_step && !sync_rise && !restart
    && present_count == 0 |=> present_count == $past(preset_parameter) - 1 && wrap_flag)
    else $error("modulo count did not wrap to modulo minus one");
  chk_disabled_hold: assert property (!enable && !sync_rise && !restart ##1 !sync_rise && !restart
    |=> $stable(present_count))
    else $error("count moved while disabled");
  chk_capture_once: assert property (cap_flag && !restart |=> $stable(capture_value))
    else $error("capture register changed while flag set");
  chk_preset_reject: assert property (rd_cycle && pwrite && paddr == hsc_pkg::OFS_PRESET
    && $signed(CW'(pwdata)) < threshold_one_parameter |=> pslverr && error ##1 $stable(preset_parameter))
    else $error("preset below threshold one was accepted");
  chk_fast_freeze: assert property (ctrl[hsc_pkg::CTRL_HOLD] |=> $stable(fast_output_zero)
    && $stable(fast_output_one))
    else $error("fast outputs moved during compare hold");
  chk_ack_sync: assert property (sync_flag && ack_sync_rise && !sync_rise |=> !sync_flag)
    else $error("sync acknowledge did not clear the flag");
  chk_restart_cfg: assert property (restart |=> preset_parameter == CW'(CFG_PRESET)
    && threshold_one_parameter == CW'(CFG_TH1) && !validity)
    else $error("restart did not restore configured parameters");
endmodule // hsc_counter

/* File: dv/pulse_source.sv */
`timescale 1ns/100ps
// Encoder stand-in; levels are held two clocks so that no edge is lost.
module pulse_source (
  input wire logic pclk, // System clock.
  output logic a_out, // Channel A.
  output logic b_out // Channel B.
);
  // Both channels rest low between pairs.
  initial begin
    a_out = 1'b0;
    b_out = 1'b0;
  end
  // Sets {b,a} just after an edge, then holds it.
  task step(input logic [1:0] v);
    @(posedge pclk);
    {b_out, a_out} <= v;
    @(posedge pclk);
  endtask
  // One quadrature pair; the leading channel gives the direction.
  task pair(input logic up);
    step(up ? 2'b01 : 2'b10);
    step(2'b11);
    step(up ? 2'b10 : 2'b01);
    step(2'b00);
  endtask
endmodule // pulse_source

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic enable_in = 1'b1;
  logic sync_in = 1'b0, capture_in = 1'b0, ack_sync = 1'b0, ack_cap = 1'b0, ack_wrap = 1'b0, warm_restart = 1'b0;
  logic a_in, b_in, pready, pslverr, fast_output_zero, fast_output_one, run, validity, error, rerr;
  logic [31:0] prdata, rdata;
  int fails = 0;
  int checks_done = 0;
  // Clock at 125 MHz.
  always #4 pclk = ~pclk;
  hsc_counter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .a_in, .b_in, .enable_in, .sync_in, .capture_in, .ack_sync, .ack_cap,
    .ack_wrap, .warm_restart, .fast_output_zero, .fast_output_one, .run, .validity, .error);
  pulse_source src (.pclk, .a_out(a_in), .b_out(b_in));
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rdata);
  endtask
  task st(input string what, input int b, input logic e);
    apb(1'b0, hsc_pkg::OFS_STATUS, 32'h0);
    check(what, {31'h0, e}, {31'h0, rdata[b]});
  endtask
  // Drives one event input by its number.
  task set_ev(input int i, input logic v);
    case (i)
      0: sync_in <= v;
      1: capture_in <= v;
      2: ack_sync <= v;
      3: ack_cap <= v;
      4: ack_wrap <= v;
      default: warm_restart <= v;
    endcase
  endtask
  // Rising edge on one event input, held long enough to be seen.
  task pulse(input int i);
    @(posedge pclk);
    set_ev(i, 1'b1);
    repeat (2) @(posedge pclk);
    set_ev(i, 1'b0);
    repeat (3) @(posedge pclk);
  endtask
  task give_verdict;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Sized well past the whole sequence, so only a hang trips it.
  initial begin
    #200000;
    fails++;
    give_verdict;
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", hsc_pkg::OFS_CTRL, 32'h40);
    rd("preset", hsc_pkg::OFS_PRESET, 32'h12c);
    rd("th1", hsc_pkg::OFS_TH1, 32'hc8);
    check("valid", 32'h1, {31'h0, validity});
    apb(1'b1, hsc_pkg::OFS_PRESET, 32'h96);
    check("refused", 32'h1, {31'h0, rerr});
    rd("kept", hsc_pkg::OFS_PRESET, 32'h12c);
    check("error", 32'h1, {31'h0, error});
    rd("diag", hsc_pkg::OFS_DIAG, 32'h1);
    apb(1'b1, hsc_pkg::OFS_DIAG, 32'h0);
    @(negedge pclk); // The clear lands on the completing edge, so look once it has settled.
    check("err clr", 32'h0, {31'h0, error});
    apb(1'b1, hsc_pkg::OFS_TH0, 32'h0);
    rd("th order", hsc_pkg::OFS_DIAG, 32'h2);
    apb(1'b1, hsc_pkg::OFS_TH0, 32'h2);
    apb(1'b1, hsc_pkg::OFS_TH1, 32'h4);
    apb(1'b1, hsc_pkg::OFS_PRESET, 32'h6);
    rd("new preset", hsc_pkg::OFS_PRESET, 32'h6);
    apb(1'b1, hsc_pkg::OFS_CTRL, 32'h42);
    pulse(0);
    rd("loaded", hsc_pkg::OFS_COUNT, 32'h6);
    st("sync", hsc_pkg::ST_SYNC, 1'b1);
    repeat (6) src.pair(1'b0);
    check("run", 32'h0, {31'h0, run});
    st("wrap", hsc_pkg::ST_WRAP, 1'b1);
    src.pair(1'b0);
    rd("stopped", hsc_pkg::OFS_COUNT, 32'h0);
    apb(1'b1, hsc_pkg::OFS_CTRL, 32'h5b);
    pulse(4);
    pulse(0);
    rd("sync zero", hsc_pkg::OFS_COUNT, 32'h0);
    repeat (4) src.pair(1'b1);
    rd("up", hsc_pkg::OFS_COUNT, 32'h4);
    st("th1 up", hsc_pkg::ST_TH1, 1'b1);
    st("reflex_one_state", hsc_pkg::ST_REFLEX_ONE_STATE, 1'b1);
    st("physical_output_one_state", hsc_pkg::ST_PHYSICAL_OUTPUT_ONE_STATE, 1'b1);
    check("fast1", 32'h1, {31'h0, fast_output_one});
    check("fast0", 32'h1, {31'h0, fast_output_zero});
    repeat (2) src.pair(1'b1);
    rd("wrap up", hsc_pkg::OFS_COUNT, 32'h0);
    st("wrap flag", hsc_pkg::ST_WRAP, 1'b1);
    src.pair(1'b0);
    rd("wrap down", hsc_pkg::OFS_COUNT, 32'h5);
    src.pair(1'b0);
    st("th1 down", hsc_pkg::ST_TH1, 1'b0);
    enable_in <= 1'b0;
    src.pair(1'b1);
    rd("held", hsc_pkg::OFS_COUNT, 32'h4);
    enable_in <= 1'b1;
    pulse(1);
    st("cap", hsc_pkg::ST_CAP, 1'b1);
    src.pair(1'b1);
    pulse(1);
    rd("no recapture", hsc_pkg::OFS_CAPTURE, 32'h4);
    pulse(3);
    st("cap clr", hsc_pkg::ST_CAP, 1'b0);
    pulse(2);
    st("sync clr", hsc_pkg::ST_SYNC, 1'b0);
    pulse(0);
    rd("resync", hsc_pkg::OFS_COUNT, 32'h0);
    apb(1'b1, hsc_pkg::OFS_CTRL, 32'h7b);
    repeat (2) src.pair(1'b0);
    rd("count on", hsc_pkg::OFS_COUNT, 32'h4);
    st("th1 held", hsc_pkg::ST_TH1, 1'b1);
    check("fast1 held", 32'h1, {31'h0, fast_output_one});
    apb(1'b1, hsc_pkg::OFS_CTRL, 32'h45);
    pulse(0);
    src.pair(1'b1);
    rd("simple down", hsc_pkg::OFS_COUNT, 32'h5);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h1, {31'h0, rerr});
    pulse(5);
    rd("restored", hsc_pkg::OFS_PRESET, 32'h12c);
    give_verdict;
  end
endmodule // tb
